// ==== verilog/tcc_pkg.sv ====
// tcc_pkg: constants and types for the timer capture/compare/pwm channel block
// assumes a single 50 MHz bus clock and plain control ports, no register bus
package tcc_pkg;
  localparam int CNT_W = 16;
  localparam int PS_W = 3;
  localparam logic [15:0] MOD_RESET = 16'hffff;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [6:0] DIV_RESET = 7'h00;
  localparam logic [2:0] PS_MAX = 3'h6;
  // channel mode from mode_sel_b:mode_sel_a
  typedef enum logic [1:0] {
    TCC_MODE_CAPTURE = 2'b00,
    TCC_MODE_COMPARE = 2'b01,
    TCC_MODE_BUFFERED = 2'b10,
    TCC_MODE_BUF_ALT = 2'b11
  } tcc_mode_type;
  // edge/level select b:a
  localparam logic [1:0] ELS_OFF = 2'b00;
  localparam logic [1:0] ELS_RISE_TOGGLE = 2'b01;
  localparam logic [1:0] ELS_FALL_CLEAR = 2'b10;
  localparam logic [1:0] ELS_BOTH_SET = 2'b11;
endpackage : tcc_pkg

// ==== verilog/tcc_channel.sv ====
// tcc_channel: one capture/compare channel pin path
// assumes counter, tick and overflow come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module tcc_channel (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic overflow,
  input wire logic [15:0] counter,
  input wire logic [15:0] compare_value,
  input wire logic capture_mode,
  input wire logic active,
  input wire logic [1:0] edge_level_select,
  input wire logic toggle_on_overflow,
  input wire logic max_duty,
  input wire logic pin_in,
  output logic pin_out,
  output logic capture_pulse,
  output logic compare_pulse
);
  logic [2:0] sync;
  logic rise;
  logic fall;
  logic hit;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync <= 3'h0;
    end else begin
      sync <= {sync[1:0], pin_in};
    end
  end

  // change counts once stages two and three differ
  assign rise = sync[1] & ~sync[2];
  assign fall = ~sync[1] & sync[2];
  // match checked only on counter ticks, so a passed value waits a period
  assign hit = tick & (counter == compare_value);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      capture_pulse <= 1'b0;
    end else begin
      capture_pulse <= active & capture_mode &
        ((edge_level_select[0] & rise) | (edge_level_select[1] & fall));
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      compare_pulse <= 1'b0;
    end else begin
      compare_pulse <= active & ~capture_mode & hit;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_out <= 1'b0;
    end else if (!active || capture_mode) begin
      pin_out <= 1'b0;
    end else if (tick && overflow && toggle_on_overflow) begin
      // toggle at modulo; max duty keeps pin on when edge_level_select[0] is clear, else still toggles
      pin_out <= max_duty ? ~edge_level_select[0] | ~pin_out : ~pin_out;
    end else if (hit && !max_duty) begin
      unique case (edge_level_select)
        tcc_pkg::ELS_RISE_TOGGLE: pin_out <= ~pin_out;
        tcc_pkg::ELS_FALL_CLEAR: pin_out <= 1'b0;
        tcc_pkg::ELS_BOTH_SET: pin_out <= 1'b1;
        tcc_pkg::ELS_OFF: pin_out <= pin_out;
      endcase
    end
  end
endmodule : tcc_channel
`default_nettype wire

// ==== verilog/tcc_top.sv ====
// tcc_top: 16-bit timer counter, prescaler and two capture/compare channels
// assumes software drives control ports synchronously to CLK
`timescale 1ns/1ps
`default_nettype none
module tcc_top (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic COUNTER_STOP,
  input wire logic COUNTER_RESET,
  input wire logic [2:0] PRESCALE_SELECT,
  input wire logic [15:0] MODULO,
  input wire logic [15:0] WRITE_DATA,
  input wire logic CH0_VALUE_WRITE,
  input wire logic CH1_VALUE_WRITE,
  input wire logic [1:0] CH0_MODE,
  input wire logic [1:0] CH1_MODE,
  input wire logic [1:0] CH0_EDGE_LEVEL,
  input wire logic [1:0] CH1_EDGE_LEVEL,
  input wire logic CH0_TOGGLE_ON_OVERFLOW,
  input wire logic CH1_TOGGLE_ON_OVERFLOW,
  input wire logic CH0_MAX_DUTY,
  input wire logic CH1_MAX_DUTY,
  input wire logic CH0_IRQ_ENABLE,
  input wire logic CH1_IRQ_ENABLE,
  input wire logic CH0_FLAG_CLEAR,
  input wire logic CH1_FLAG_CLEAR,
  input wire logic CHANNEL0_PIN_IN,
  input wire logic CHANNEL1_PIN_IN,
  output logic CHANNEL0_PIN_OUT,
  output logic CHANNEL0_PIN_OE,
  output logic CHANNEL1_PIN_OUT,
  output logic CHANNEL1_PIN_OE,
  output logic [15:0] COUNTER,
  output logic [15:0] CH0_VALUE,
  output logic [15:0] CH1_VALUE,
  output logic CH0_FLAG,
  output logic CH1_FLAG,
  output logic CH0_IRQ,
  output logic CH1_IRQ,
  output logic OVERFLOW_EVENT,
  output logic ACTIVE_PAIR
);
  logic [6:0] divider;
  logic tick;
  logic at_modulo;
  logic [15:0] next_count;
  logic link_mode_bit;
  logic pending_pair;
  logic pending_swap;
  logic [15:0] active_value;
  logic ch0_pin;
  logic ch1_pin;
  logic ch0_cap;
  logic ch1_cap;
  logic ch0_cmp;
  logic ch1_cmp;
  logic ch0_event;
  logic ch1_event;

  function automatic logic is_output(input logic [1:0] mode, input logic [1:0] els);
    is_output = (mode != tcc_pkg::TCC_MODE_CAPTURE) && (els != tcc_pkg::ELS_OFF);
  endfunction : is_output

  // channel 0 mode b set links the pair
  assign link_mode_bit = CH0_MODE[1];
  assign at_modulo = (COUNTER == MODULO);

  // seven rates: divide by 1,2,4,...,64
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      divider <= tcc_pkg::DIV_RESET;
    end else if (COUNTER_RESET) begin
      divider <= tcc_pkg::DIV_RESET;
    end else if (!COUNTER_STOP) begin
      divider <= divider + 7'h01;
    end
  end

  always_comb begin
    unique case (PRESCALE_SELECT)
      3'h0: tick = 1'b1;
      3'h1: tick = divider[0];
      3'h2: tick = &divider[1:0];
      3'h3: tick = &divider[2:0];
      3'h4: tick = &divider[3:0];
      3'h5: tick = &divider[4:0];
      3'h6: tick = &divider[5:0];
      default: tick = &divider[5:0];
    endcase
    tick = tick & ~COUNTER_STOP & ~COUNTER_RESET;
  end

  // count entered on this tick; wrap at modulo gives modulo plus one
  assign next_count = at_modulo ? tcc_pkg::CNT_RESET : COUNTER + 16'h0001;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      COUNTER <= tcc_pkg::CNT_RESET;
    end else if (COUNTER_RESET) begin
      COUNTER <= tcc_pkg::CNT_RESET;
    end else if (tick) begin
      COUNTER <= next_count;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      OVERFLOW_EVENT <= 1'b0;
    end else begin
      OVERFLOW_EVENT <= tick & at_modulo;
    end
  end

  // capture wins over software write of the same pair
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CH0_VALUE <= tcc_pkg::CNT_RESET;
    end else if (ch0_cap) begin
      CH0_VALUE <= COUNTER;
    end else if (CH0_VALUE_WRITE) begin
      CH0_VALUE <= WRITE_DATA;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CH1_VALUE <= tcc_pkg::CNT_RESET;
    end else if (ch1_cap && !link_mode_bit) begin
      CH1_VALUE <= COUNTER;
    end else if (CH1_VALUE_WRITE) begin
      CH1_VALUE <= WRITE_DATA;
    end
  end

  // remember last written pair, swap at overflow
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pending_pair <= 1'b0;
      pending_swap <= 1'b0;
    end else if (!link_mode_bit) begin
      pending_pair <= 1'b0;
      pending_swap <= 1'b0;
    end else if (CH1_VALUE_WRITE) begin
      pending_pair <= 1'b1;
      pending_swap <= 1'b1;
    end else if (CH0_VALUE_WRITE) begin
      pending_pair <= 1'b0;
      pending_swap <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ACTIVE_PAIR <= 1'b0;
    end else if (!link_mode_bit) begin
      ACTIVE_PAIR <= 1'b0;
    end else if (tick && at_modulo && pending_swap) begin
      ACTIVE_PAIR <= pending_pair;
    end
  end

  // writes to the active pair act at once, as unbuffered
  assign active_value = (link_mode_bit && ACTIVE_PAIR) ? CH1_VALUE : CH0_VALUE;

  tcc_channel u_ch0 (
    .clk(CLK),
    .resetn(RESETN),
    .tick(tick),
    .overflow(at_modulo),
    // compare acts as the count is entered, like the wrap toggle
    .counter(next_count),
    .compare_value(active_value),
    .capture_mode(CH0_MODE == tcc_pkg::TCC_MODE_CAPTURE),
    .active(1'b1),
    .edge_level_select(CH0_EDGE_LEVEL),
    .toggle_on_overflow(CH0_TOGGLE_ON_OVERFLOW),
    .max_duty(CH0_MAX_DUTY),
    .pin_in(CHANNEL0_PIN_IN),
    .pin_out(ch0_pin),
    .capture_pulse(ch0_cap),
    .compare_pulse(ch0_cmp)
  );

  // channel 1 idle while linked
  tcc_channel u_ch1 (
    .clk(CLK),
    .resetn(RESETN),
    .tick(tick),
    .overflow(at_modulo),
    .counter(next_count),
    .compare_value(CH1_VALUE),
    .capture_mode(CH1_MODE == tcc_pkg::TCC_MODE_CAPTURE),
    .active(~link_mode_bit),
    .edge_level_select(CH1_EDGE_LEVEL),
    .toggle_on_overflow(CH1_TOGGLE_ON_OVERFLOW),
    .max_duty(CH1_MAX_DUTY),
    .pin_in(CHANNEL1_PIN_IN),
    .pin_out(ch1_pin),
    .capture_pulse(ch1_cap),
    .compare_pulse(ch1_cmp)
  );

  assign ch0_event = ch0_cap | ch0_cmp;
  assign ch1_event = ch1_cap | ch1_cmp;

  // set wins over clear
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CH0_FLAG <= 1'b0;
      CH1_FLAG <= 1'b0;
    end else begin
      CH0_FLAG <= ch0_event | (CH0_FLAG & ~CH0_FLAG_CLEAR);
      CH1_FLAG <= ch1_event | (CH1_FLAG & ~CH1_FLAG_CLEAR);
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CH0_IRQ <= 1'b0;
      CH1_IRQ <= 1'b0;
    end else begin
      CH0_IRQ <= CH0_IRQ_ENABLE & (ch0_event | (CH0_FLAG & ~CH0_FLAG_CLEAR));
      CH1_IRQ <= CH1_IRQ_ENABLE & (ch1_event | (CH1_FLAG & ~CH1_FLAG_CLEAR));
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CHANNEL0_PIN_OUT <= 1'b0;
      CHANNEL0_PIN_OE <= 1'b0;
      CHANNEL1_PIN_OUT <= 1'b0;
      CHANNEL1_PIN_OE <= 1'b0;
    end else begin
      CHANNEL0_PIN_OUT <= ch0_pin;
      CHANNEL0_PIN_OE <= is_output(CH0_MODE, CH0_EDGE_LEVEL);
      CHANNEL1_PIN_OUT <= ch1_pin;
      CHANNEL1_PIN_OE <= ~link_mode_bit & is_output(CH1_MODE, CH1_EDGE_LEVEL);
    end
  end
endmodule : tcc_top
`default_nettype wire

// ==== sim/tcc_monitor.sv ====
// tcc_monitor: timing checks on the tcc_top ports
// assumes the bench changes inputs at the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module tcc_monitor (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic COUNTER_STOP,
  input wire logic COUNTER_RESET,
  input wire logic [2:0] PRESCALE_SELECT,
  input wire logic [15:0] MODULO,
  input wire logic [15:0] WRITE_DATA,
  input wire logic CH0_VALUE_WRITE,
  input wire logic [1:0] CH0_MODE,
  input wire logic [1:0] CH0_EDGE_LEVEL,
  input wire logic CH0_IRQ_ENABLE,
  input wire logic CH0_MAX_DUTY,
  input wire logic CHANNEL0_PIN_IN,
  input wire logic CHANNEL0_PIN_OUT,
  input wire logic CHANNEL1_PIN_OE,
  input wire logic [15:0] COUNTER,
  input wire logic [15:0] CH0_VALUE,
  input wire logic CH0_FLAG,
  input wire logic CH0_IRQ,
  input wire logic OVERFLOW_EVENT
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  // undivided clock, counter running
  wire run = PRESCALE_SELECT == 3'h0 && !COUNTER_STOP && !COUNTER_RESET;
  // counter ticks into the unchanged compare value
  sequence s_match;
    run && CH0_MODE == 2'b01 ##1 COUNTER == CH0_VALUE && $stable(CH0_VALUE);
  endsequence
  sequence s_wrap;
    run && COUNTER == MODULO;
  endsequence
  a_count_step: assert property (
    run && COUNTER != MODULO |=> COUNTER == $past(COUNTER) + 16'h1) else $error("bad step");
  a_wrap_zero: assert property (
    s_wrap |=> COUNTER == 16'h0 && OVERFLOW_EVENT) else $error("bad wrap");
  a_match_flag: assert property (
    s_match |-> ##1 CH0_FLAG) else $error("no compare flag");
  a_match_level: assert property (
    s_match ##0 (CH0_EDGE_LEVEL[1] && $stable(CH0_EDGE_LEVEL) && COUNTER != 16'h0 &&
    !CH0_MAX_DUTY && $stable(CH0_MAX_DUTY))
    |-> ##1 CHANNEL0_PIN_OUT == $past(CH0_EDGE_LEVEL[0])) else $error("bad pin");
  a_write_value: assert property (
    CH0_VALUE_WRITE && CH0_MODE != 2'b00 |=> CH0_VALUE == $past(WRITE_DATA))
    else $error("bad write");
  a_irq_on: assert property (
    (CH0_FLAG && CH0_IRQ_ENABLE) [*2] |-> CH0_IRQ) else $error("no irq");
  a_ch1_release: assert property (
    CH0_MODE[1] [*2] |-> !CHANNEL1_PIN_OE) else $error("ch1 pin held");
  a_capture_flag: assert property (
    $rose(CHANNEL0_PIN_IN) && CH0_MODE == 2'b00 && CH0_EDGE_LEVEL[0] |-> ##[3:6] CH0_FLAG)
    else $error("no capture");
endmodule : tcc_monitor
bind tcc_top tcc_monitor tcc_monitor_inst (.*);
`default_nettype wire

// ==== sim/tcc_pin_model.sv ====
// tcc_pin_model: event sources and loads on the two channel pins
// assumes the bench changes source levels at the clock falling edge
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
  input wire logic src0,
  input wire logic src1,
  input wire logic out0,
  input wire logic oe0,
  input wire logic out1,
  input wire logic oe1,
  output logic pin0,
  output logic pin1
);
  // driver wins, else the external source
  assign pin0 = oe0 ? out0 : src0;
  assign pin1 = oe1 ? out1 : src1;
endmodule : tcc_pin_model
`default_nettype wire

// ==== sim/tb_tcc_top.sv ====
// tb_tcc_top: self-checking bench for the capture/compare/pwm timer
// assumes tcc_monitor is bound in and tcc_pin_model loads the pins
`timescale 1ns/1ps
`default_nettype none
module tb_tcc_top;
  logic CLK = 1'b0, RESETN = 1'b0, COUNTER_STOP = 1'b0, COUNTER_RESET = 1'b1;
  logic [2:0] PRESCALE_SELECT = 3'h0;
  logic [15:0] MODULO = 16'hffff, WRITE_DATA = 16'h0;
  logic CH0_VALUE_WRITE = 1'b0, CH1_VALUE_WRITE = 1'b0, CH0_FLAG_CLEAR = 1'b0;
  logic [1:0] CH0_MODE = 2'b00, CH1_MODE = 2'b00, CH0_EDGE_LEVEL = 2'b01, CH1_EDGE_LEVEL = 2'b01;
  logic CH0_TOGGLE_ON_OVERFLOW = 1'b0, CH1_TOGGLE_ON_OVERFLOW = 1'b0, CH1_FLAG_CLEAR = 1'b0;
  logic CH0_MAX_DUTY = 1'b0, CH1_MAX_DUTY = 1'b0, CH0_IRQ_ENABLE = 1'b0, CH1_IRQ_ENABLE = 1'b1;
  logic CHANNEL0_PIN_IN, CHANNEL1_PIN_IN, CHANNEL0_PIN_OUT, CHANNEL0_PIN_OE, CHANNEL1_PIN_OUT;
  logic CHANNEL1_PIN_OE, CH0_FLAG, CH1_FLAG, CH0_IRQ, CH1_IRQ, OVERFLOW_EVENT, ACTIVE_PAIR;
  logic [15:0] COUNTER, CH0_VALUE, CH1_VALUE, e, w;
  logic [15:0] notes[$];
  logic src0 = 1'b0, src1 = 1'b0, f0q = 1'b0, hit;
  logic [31:0] seed = 32'h31ce;
  int error_cnt = 0, num_checks = 0, n, hi, lo;
  tcc_top tcc_top_inst (.*);
  tcc_pin_model tcc_pin_model_inst (.src0(src0), .src1(src1), .out0(CHANNEL0_PIN_OUT),
    .oe0(CHANNEL0_PIN_OE), .out1(CHANNEL1_PIN_OUT), .oe1(CHANNEL1_PIN_OE),
    .pin0(CHANNEL0_PIN_IN), .pin1(CHANNEL1_PIN_IN));
  always #10 CLK = ~CLK;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic end_sim;
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] g);
    num_checks++;
    if (g !== ex) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, ex, g);
    end
  endtask : chk
  task automatic chkb(input string nm, input logic ex, input logic g);
    chk(nm, 16'(ex), 16'(g));
  endtask : chkb
  // bounded waits, cycles counted in c
  task automatic wcnt(input logic [15:0] v, output int c);
    c = 0;
    while (COUNTER !== v) begin
      @(negedge CLK);
      c++;
      if (c > 2000) begin
        error_cnt++;
        end_sim;
      end
    end
  endtask : wcnt
  task automatic wpin(input logic v, output int c);
    c = 0;
    while (CHANNEL0_PIN_OUT !== v) begin
      @(negedge CLK);
      c++;
      if (c > 2000) begin
        error_cnt++;
        end_sim;
      end
    end
  endtask : wpin
  task automatic wr(input logic ch, input logic [15:0] v);
    WRITE_DATA = v;
    CH0_VALUE_WRITE = !ch;
    CH1_VALUE_WRITE = ch;
    @(negedge CLK);
    CH0_VALUE_WRITE = 1'b0;
    CH1_VALUE_WRITE = 1'b0;
  endtask : wr
  task automatic clr;
    CH0_FLAG_CLEAR = 1'b1;
    CH1_FLAG_CLEAR = 1'b1;
    @(negedge CLK);
    CH0_FLAG_CLEAR = 1'b0;
    CH1_FLAG_CLEAR = 1'b0;
  endtask : clr
  task automatic pwm(input logic [15:0] ex);
    wpin(1'b0, n);
    wpin(1'b1, n);
    wpin(1'b0, hi);
    wpin(1'b1, lo);
    chk("pwm high", ex, 16'(hi));
    chk("pwm period", MODULO + 16'h1, 16'(hi + lo));
  endtask : pwm
  always @(negedge CLK) begin
    f0q <= CH0_FLAG;
    if (CH0_FLAG === 1'b1 && f0q !== 1'b1 && notes.size() > 0)
      chk("ch0 value", notes.pop_front(), CH0_VALUE);
  end
  initial begin
    repeat (10) @(negedge CLK);
    RESETN = 1'b1;
    @(negedge CLK);
    chk("counter", 16'h0, COUNTER);
    for (int p = 0; p < 8; p++) begin
      PRESCALE_SELECT = p[2:0];
      COUNTER_RESET = 1'b1;
      @(negedge CLK);
      COUNTER_RESET = 1'b0;
      wcnt(16'h1, n);
      wcnt(16'h2, n);
      chk("tick", 16'h1 << (p > 6 ? 6 : p), 16'(n));
    end
    PRESCALE_SELECT = 3'h0;
    for (int k = 1; k < 4; k++) begin
      CH0_EDGE_LEVEL = k[1:0];
      CH1_EDGE_LEVEL = k[1:0];
      for (int lv = 1; lv >= 0; lv--) begin
        seed = xs(seed);
        CH0_IRQ_ENABLE = seed[3];
        repeat (2 + seed[2:0]) @(negedge CLK);
        src0 = lv[0];
        src1 = lv[0];
        e = COUNTER + 16'h3;
        hit = lv ? k[0] : k[1];
        if (hit) notes.push_back(e);
        repeat (8) @(negedge CLK);
        chkb("ch1 flag", hit, CH1_FLAG);
        if (hit) chk("ch1 value", e, CH1_VALUE);
        chkb("ch0 irq", hit & CH0_IRQ_ENABLE, CH0_IRQ);
        chkb("ch1 irq", hit, CH1_IRQ);
        clr;
      end
    end
    seed = xs(seed);
    e = 16'h10 + 16'(seed[4:0]);
    MODULO = 16'h003f;
    CH0_MODE = 2'b01;
    CH0_EDGE_LEVEL = 2'b01;
    COUNTER_RESET = 1'b1;
    wr(1'b0, e);
    COUNTER_RESET = 1'b0;
    notes.push_back(e);
    wcnt(e + 16'h3, n);
    chkb("toggle", 1'b1, CHANNEL0_PIN_OUT);
    chkb("ch0 oe", 1'b1, CHANNEL0_PIN_OE);
    w = e - 16'h8;
    wr(1'b0, w);
    clr;
    wcnt(16'h003f, n);
    chkb("passed", 1'b0, CH0_FLAG);
    notes.push_back(w);
    for (int k = 2; k < 4; k++) begin
      CH0_EDGE_LEVEL = k[1:0];
      wcnt(16'h0, n);
      wcnt(w + 16'h3, n);
      chkb("level", k[0], CHANNEL0_PIN_OUT);
    end
    COUNTER_STOP = 1'b1;
    COUNTER_RESET = 1'b1;
    MODULO = 16'h00ff;
    CH0_EDGE_LEVEL = 2'b10;
    CH0_TOGGLE_ON_OVERFLOW = 1'b1;
    wr(1'b0, 16'h0080);
    COUNTER_RESET = 1'b0;
    COUNTER_STOP = 1'b0;
    pwm(16'h0080);
    wcnt(16'h0085, n);
    wr(1'b0, 16'h0040);
    pwm(16'h0040);
    wcnt(16'h0002, n);
    wr(1'b0, 16'h00c0);
    pwm(16'h00c0);
    COUNTER_STOP = 1'b1;
    COUNTER_RESET = 1'b1;
    MODULO = 16'h003f;
    CH0_MODE = 2'b10;
    wr(1'b0, 16'h0010);
    COUNTER_RESET = 1'b0;
    COUNTER_STOP = 1'b0;
    pwm(16'h0010);
    chkb("pair", 1'b0, ACTIVE_PAIR);
    wr(1'b1, 16'h0020);
    pwm(16'h0020);
    chkb("pair", 1'b1, ACTIVE_PAIR);
    chkb("ch1 oe", 1'b0, CHANNEL1_PIN_OE);
    chkb("ch1 out", 1'b0, CHANNEL1_PIN_OUT);
    src1 = 1'b1;
    repeat (8) @(negedge CLK);
    chkb("ch1 flag", 1'b0, CH1_FLAG);
    wr(1'b0, 16'h0008);
    pwm(16'h0008);
    chkb("pair", 1'b0, ACTIVE_PAIR);
    // max duty with toggle on overflow keeps the pin on past the compare
    CH0_MAX_DUTY = 1'b1;
    wcnt(16'h0020, n);
    chkb("max duty", 1'b1, CHANNEL0_PIN_OUT);
    chk("notes left", 16'h0, 16'(notes.size()));
    end_sim;
  end
endmodule : tb_tcc_top
`default_nettype wire
